/* File: src/pfs_regs.vh */
`ifndef PFS_REGS_VH
`define PFS_REGS_VH
`define PFS_CLK_HZ 25000000
`define PFS_START_PULSES 2'h3
`define PFS_RETRY_PULSES 2'h2
`define PFS_UV_OFF_PERIODS 12'h800
`define PFS_OVL_DELAY 13'h1800
`define PFS_SLEEP_TIME 17'h10000
`define PFS_BLANK_CLKS 3'h4
`define PFS_AXI_CTRL 5'h0
`define PFS_AXI_STAT 5'h4
`define PFS_AXI_IRQ_STAT 5'h8
`define PFS_AXI_IRQ_CLR 5'hc
`define PFS_AXI_IRQ_EN 5'h10
`define PFS_CTRL_RESET 1'h1
`endif

/* File: src/pfs_sequencer.v */
`timescale 1ns/10ps
`include "pfs_regs.vh"
module pfs_sequencer #(
  parameter SLEEP_TIME = `PFS_SLEEP_TIME,
  parameter OVL_DELAY = `PFS_OVL_DELAY
) (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire line_uv_i,
  input wire line_recovered_i,
  input wire feedback_over_i,
  input wire thermal_below_i,
  input wire pwm_pulse_i,
  input wire period_i,
  output reg gate_o,
  output reg softstart_reset_o,
  output reg blanking_o,
  output reg otp_enable_o,
  output reg irq_o,
  input wire [4:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [4:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i
);
  localparam ST_BLANK = 6'h01;
  localparam ST_START = 6'h02;
  localparam ST_RUN = 6'h04;
  localparam ST_UVOFF = 6'h08;
  localparam ST_BURST = 6'h10;
  localparam ST_SLEEP = 6'h20;

  // three-stage synchronisers, a change counts once stages two and three agree
  reg [4:0] s1_reg;
  reg [4:0] s2_reg;
  reg [4:0] s3_reg;
  reg [4:0] in_reg;
  wire [4:0] raw = {period_i, pwm_pulse_i, thermal_below_i, feedback_over_i,
                    line_uv_i | ~line_recovered_i};
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : sync
      always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
          s1_reg[g] <= 1'b0;
          s2_reg[g] <= 1'b0;
          s3_reg[g] <= 1'b0;
          in_reg[g] <= 1'b0;
        end else begin
          s1_reg[g] <= raw[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          if (s2_reg[g] == s3_reg[g]) begin
            in_reg[g] <= s3_reg[g];
          end
        end
      end
    end
  endgenerate
  wire uv = in_reg[0];
  wire fb_over = in_reg[1];
  wire cold = in_reg[2];
  reg pulse_d_reg;
  reg period_d_reg;
  wire pulse_edge = in_reg[3] & ~pulse_d_reg;
  wire period_tick = in_reg[4] & ~period_d_reg;

  reg [5:0] state_reg;
  reg [5:0] state_next;
  reg [1:0] pcnt_reg;
  reg [11:0] uvcnt_reg;
  reg [12:0] ovl_reg;
  reg [16:0] sleep_reg;
  reg [2:0] blank_reg;
  reg recovered_once_reg;
  reg enable_reg;
  reg [3:0] ev_stat_reg;
  reg [3:0] ev_en_reg;

  wire ovl_trip = fb_over && (ovl_reg >= OVL_DELAY - 13'h1);
  wire gating = (state_reg == ST_RUN) || (state_reg == ST_START) ||
                (state_reg == ST_BURST);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_BLANK: begin
        if (blank_reg == `PFS_BLANK_CLKS - 3'h1) begin
          state_next = ST_START;
        end
      end
      ST_START: begin
        if (ovl_trip) begin
          state_next = ST_SLEEP;
        end else if (!uv) begin
          state_next = ST_RUN;
        end else if (!recovered_once_reg && !in_reg[3] &&
                     pcnt_reg == `PFS_START_PULSES) begin
          // leave only once the last counted pulse has ended, so it goes out whole
          state_next = ST_UVOFF;
        end else if (recovered_once_reg) begin
          state_next = ST_UVOFF;
        end
      end
      ST_RUN: begin
        if (ovl_trip) begin
          state_next = ST_SLEEP;
        end else if (uv) begin
          state_next = ST_UVOFF;
        end
      end
      ST_UVOFF: begin
        if (uvcnt_reg == `PFS_UV_OFF_PERIODS - 12'h1 && period_tick) begin
          state_next = uv ? ST_BURST : ST_RUN;
        end else if (!uv && !recovered_once_reg) begin
          state_next = ST_RUN;
        end
      end
      ST_BURST: begin
        if (ovl_trip) begin
          state_next = ST_SLEEP;
        end else if (!uv) begin
          state_next = ST_RUN;
        end else if (!in_reg[3] && pcnt_reg == `PFS_RETRY_PULSES) begin
          // same as at start: the second pulse finishes before the off interval
          state_next = ST_UVOFF;
        end
      end
      ST_SLEEP: begin
        if (sleep_reg == SLEEP_TIME - 17'h1) begin
          state_next = ST_BLANK;
        end
      end
      default: state_next = ST_BLANK;
    endcase
    if (!enable_reg) begin
      state_next = ST_BLANK;
    end
  end

  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_reg <= ST_BLANK;
      pcnt_reg <= 2'h0;
      uvcnt_reg <= 12'h0;
      ovl_reg <= 13'h0;
      sleep_reg <= 17'h0;
      blank_reg <= 3'h0;
      recovered_once_reg <= 1'b0;
      pulse_d_reg <= 1'b0;
      period_d_reg <= 1'b0;
      gate_o <= 1'b0;
      softstart_reset_o <= 1'b1;
      blanking_o <= 1'b1;
      otp_enable_o <= 1'b0;
    end else begin
      pulse_d_reg <= in_reg[3];
      period_d_reg <= in_reg[4];
      state_reg <= state_next;
      if (state_reg == ST_RUN) begin
        recovered_once_reg <= 1'b1;
      end
      // pulse edges are counted within one state only
      if (state_next != state_reg) begin
        pcnt_reg <= 2'h0;
      end else if (pulse_edge) begin
        pcnt_reg <= pcnt_reg + 2'h1;
      end
      // off interval is measured in switching periods, not clocks
      if (state_reg != ST_UVOFF) begin
        uvcnt_reg <= 12'h0;
      end else if (period_tick) begin
        uvcnt_reg <= uvcnt_reg + 12'h1;
      end
      // overload time accumulates across on intervals, dropping out short of it does not clear the count
      if (!gating) begin
        ovl_reg <= 13'h0;
      end else if (fb_over && !ovl_trip) begin
        ovl_reg <= ovl_reg + 13'h1;
      end
      // sleep and blanking are measured in clock periods
      if (state_reg != ST_SLEEP) begin
        sleep_reg <= 17'h0;
      end else begin
        sleep_reg <= sleep_reg + 17'h1;
      end
      if (state_reg != ST_BLANK) begin
        blank_reg <= 3'h0;
      end else begin
        blank_reg <= blank_reg + 3'h1;
      end
      // a pulse passes only from its own rising edge, never as a cut remnant
      gate_o <= (state_next == ST_RUN || state_next == ST_START ||
                 state_next == ST_BURST) && in_reg[3] && (pulse_edge || gate_o);
      softstart_reset_o <= (state_next == ST_SLEEP) || (state_next == ST_BLANK);
      blanking_o <= (state_next == ST_BLANK);
      otp_enable_o <= cold;
    end
  end

  // bus slave: ctrl bit0 enables switching; status shows state; events sticky
  reg aw_got_reg;
  reg w_got_reg;
  reg [4:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  // events: retry burst, off entered, sleep ended, sleep entered
  wire [3:0] ev_set = {state_next == ST_BURST && state_reg != ST_BURST,
                       state_next == ST_UVOFF && state_reg != ST_UVOFF,
                       state_next == ST_BLANK && state_reg == ST_SLEEP,
                       state_next == ST_SLEEP && state_reg != ST_SLEEP};
  wire do_write = aw_got_reg && w_got_reg && !s_axi_bvalid_o;
  wire clr_hit = do_write && aw_addr_reg == `PFS_AXI_IRQ_CLR && w_strb_reg[0];

  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 5'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= 2'h0;
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= 2'h0;
      enable_reg <= `PFS_CTRL_RESET;
      ev_stat_reg <= 4'h0;
      ev_en_reg <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= 2'h0;
        if (w_strb_reg[0]) begin
          case (aw_addr_reg)
            `PFS_AXI_CTRL: enable_reg <= w_data_reg[0];
            `PFS_AXI_IRQ_EN: ev_en_reg <= w_data_reg[3:0];
            `PFS_AXI_IRQ_CLR: ;
            default: s_axi_bresp_o <= 2'h2;
          endcase
        end
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
      // set wins over clear
      ev_stat_reg <= (ev_stat_reg & ~(clr_hit ? w_data_reg[3:0] : 4'h0)) | ev_set;
      irq_o <= |(ev_stat_reg & ev_en_reg);
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= 2'h0;
        case (s_axi_araddr_i)
          `PFS_AXI_CTRL: s_axi_rdata_o <= {31'h0, enable_reg};
          `PFS_AXI_STAT: s_axi_rdata_o <= {24'h0, cold, gate_o, state_reg};
          `PFS_AXI_IRQ_STAT: s_axi_rdata_o <= {28'h0, ev_stat_reg};
          `PFS_AXI_IRQ_EN: s_axi_rdata_o <= {28'h0, ev_en_reg};
          `PFS_AXI_IRQ_CLR: s_axi_rdata_o <= 32'h0;
          default: begin
            s_axi_rdata_o <= 32'h0;
            s_axi_rresp_o <= 2'h2;
          end
        endcase
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end
endmodule

/* File: testbench/pfs_analog_model.sv */
`timescale 1ns/10ps
module pfs_analog_model (
  input wire ref_clk_i,
  input wire gate_o,
  output reg pwm_pulse_o = 1'h0,
  output reg period_o = 1'h0,
  output int n_edges_o = 0
);
  reg [2:0] ph = 3'h0;
  reg gq = 1'h0;
  // eight-clock switching cycle; the driver side counts gate pulses
  always @(posedge ref_clk_i) begin
    ph <= ph + 3'h1;
    pwm_pulse_o <= ph < 3'h3;
    // period marker lasts two clocks so the input agreement stage can see it
    period_o <= ph >= 3'h6;
    gq <= gate_o;
    if (gate_o && !gq)
      n_edges_o <= n_edges_o + 1;
  end
endmodule

/* File: testbench/pfs_seq_props.sv */
`timescale 1ns/10ps
module pfs_seq_props #(
  parameter SLEEP_TIME = 17'h10000,
  parameter OVL_DELAY = 13'h1800
) (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire feedback_over_i,
  input wire thermal_below_i,
  input wire gate_o,
  input wire softstart_reset_o,
  input wire blanking_o,
  input wire otp_enable_o
);
  int ovc = 0;
  int sc = 0;
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // raw overload time and sleep length, seen at the pins
  always @(posedge ref_clk_i) begin
    if (!resetn_i || softstart_reset_o)
      ovc <= 0;
    else if (feedback_over_i && !blanking_o)
      ovc <= ovc + 1;
    sc <= (softstart_reset_o && !blanking_o) ? sc + 1 : 0;
  end
  a_otp_on: assert property (thermal_below_i [*8] |-> otp_enable_o)
    else $error("otp off");
  a_otp_off: assert property (!thermal_below_i [*8] |-> !otp_enable_o)
    else $error("otp on");
  a_blank_len: assert property ($rose(blanking_o) |-> blanking_o [*4] ##1 !blanking_o)
    else $error("blank length");
  a_blank_gate: assert property (blanking_o |-> !gate_o)
    else $error("gate in blank");
  a_sleep_gate: assert property (softstart_reset_o && $past(softstart_reset_o) |-> !gate_o)
    else $error("gate in sleep");
  a_sleep_len: assert property ($fell(softstart_reset_o && !blanking_o)
    |-> sc >= SLEEP_TIME - 1 && sc <= SLEEP_TIME + 1) else $error("sleep length");
  a_ovl_early: assert property ($rose(softstart_reset_o) |-> ovc >= OVL_DELAY)
    else $error("early trip");
  a_ovl_late: assert property (ovc <= OVL_DELAY + 8)
    else $error("late trip");
  c_sleep: cover property ($rose(softstart_reset_o));
  c_blank: cover property ($rose(blanking_o));
  c_otp: cover property ($rose(otp_enable_o));
endmodule
bind pfs_sequencer pfs_seq_props #(.SLEEP_TIME(SLEEP_TIME), .OVL_DELAY(OVL_DELAY))
  u_props (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .feedback_over_i(feedback_over_i),
    .thermal_below_i(thermal_below_i),
    .gate_o(gate_o),
    .softstart_reset_o(softstart_reset_o),
    .blanking_o(blanking_o),
    .otp_enable_o(otp_enable_o)
  );

/* File: testbench/pfs_sequencer_bench.sv */
`timescale 1ns/10ps
module pfs_sequencer_bench;
  reg ref_clk_i = 0, resetn_i = 0, line_uv_i = 1, line_recovered_i = 0;
  reg feedback_over_i = 0, thermal_below_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
  reg s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  reg [4:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
  reg [31:0] s_axi_wdata_i = 0, rdat;
  reg [3:0] s_axi_wstrb_i = 4'hf;
  reg [1:0] rsp;
  wire pwm_pulse_i, period_i, gate_o, softstart_reset_o, blanking_o, otp_enable_o, irq_o;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o;
  int ne, n0, i, k, n_fail = 0, num_checks = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  pfs_sequencer #(.SLEEP_TIME(17'h40), .OVL_DELAY(13'h18)) dut (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .line_uv_i(line_uv_i),
    .line_recovered_i(line_recovered_i),
    .feedback_over_i(feedback_over_i),
    .thermal_below_i(thermal_below_i),
    .pwm_pulse_i(pwm_pulse_i),
    .period_i(period_i),
    .gate_o(gate_o),
    .softstart_reset_o(softstart_reset_o),
    .blanking_o(blanking_o),
    .otp_enable_o(otp_enable_o),
    .irq_o(irq_o),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i)
  );
  pfs_analog_model u_m (.ref_clk_i(ref_clk_i), .gate_o(gate_o), .pwm_pulse_o(pwm_pulse_i),
    .period_o(period_i), .n_edges_o(ne));
  task wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task chk(input [31:0] s, input [31:0] e, input string n);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task bus(input bit w, input [4:0] a, input [31:0] d);
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_araddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= w;
    s_axi_wvalid_i <= w;
    s_axi_bready_i <= w;
    s_axi_arvalid_i <= !w;
    s_axi_rready_i <= !w;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 0;
      if (s_axi_arready_o) s_axi_arvalid_i <= 0;
      if (s_axi_bvalid_o || s_axi_rvalid_o) break;
    end
    rdat = s_axi_rdata_o;
    rsp = w ? s_axi_bresp_o : s_axi_rresp_o;
    s_axi_bready_i <= 0;
    s_axi_rready_i <= 0;
    chk(i < 20, 1, "bus");
    if (i == 20) end_of_test;
  endtask
  task t_start_uv;
    wt(200);
    chk(ne, 3, "start");
    bus(1, 5'h10, 32'h4);
    wt(3);
    chk(irq_o, 1, "irq");
    bus(1, 5'h10, 32'h8);
    bus(1, 5'hc, 32'h4);
    wt(3);
    chk(irq_o, 0, "masked");
    wt(15700);
    chk(ne, 3, "off");
    wt(900);
    chk(ne, 5, "retry");
    chk(irq_o, 1, "irq2");
    bus(0, 5'h8, 32'h0);
    chk(rdat[3], 1, "event");
    bus(0, 5'h14, 32'h0);
    chk(rsp, 2'h2, "unmapped");
    bus(1, 5'h14, 32'h0);
    chk(rsp, 2'h2, "bad write");
    bus(0, 5'h0, 32'h0);
    chk(rdat, 32'h1, "ctrl");
    bus(0, 5'h4, 32'h0);
    chk(rdat, 32'h8, "state");
  endtask
  task t_recover;
    line_uv_i <= 0;
    line_recovered_i <= 1;
    wt(16600);
    n0 = ne;
    wt(80);
    chk(ne - n0, 10, "resume");
  endtask
  task t_run_uv;
    line_uv_i <= 1;
    wt(40);
    n0 = ne;
    wt(16000);
    chk(ne - n0, 0, "stop");
    wt(800);
    chk(ne - n0, 2, "burst");
  endtask
  task t_ovl;
    line_uv_i <= 0;
    resetn_i <= 0;
    wt(16);
    resetn_i <= 1;
    wt(50);
    feedback_over_i <= 1;
    wt(10);
    feedback_over_i <= 0;
    wt(100);
    chk(softstart_reset_o, 0, "short");
    feedback_over_i <= 1;
    k = 0;
    for (i = 0; i < 400; i++) begin
      @(posedge ref_clk_i);
      if (softstart_reset_o && !blanking_o && n0 == 0) k++;
      n0 = softstart_reset_o;
    end
    chk(k > 1, 1, "sleeps");
    feedback_over_i <= 0;
  endtask
  task t_otp;
    thermal_below_i <= 1;
    wt(3);
    chk(otp_enable_o, 0, "sync");
    wt(6);
    chk(otp_enable_o, 1, "otp on");
    thermal_below_i <= 0;
    wt(9);
    chk(otp_enable_o, 0, "otp off");
  endtask
  initial begin
    wt(16);
    resetn_i <= 1;
    t_start_uv;
    t_recover;
    t_run_uv;
    t_ovl;
    t_otp;
    end_of_test;
  end
endmodule
